// ===== hdl/tbu_pkg.sv
// constants, carriers and state codes of the tx buffer unpacker
//==========================================================
// Notes on behaviour
// - data starts third word, after two commands
// - offset low bits pick first byte lane
// - offset bits 5:2 skip whole words
// - contiguous data, unused tail bytes withheld
// - end alignment 4/16/32, filler dropped
// - any alignment, first/last any length
// - one status word per transmitted packet
// - full status fifo suspends transmission
// - discard mode keeps running, holds count zero
// - discard mode overrun raises no error
// - status 31:16 carries packet tag
// - bit 15 ORs bits 11,10,9,8,2,1
// - bits 11/10 loss of and no carrier
// - bit 9 late collision
// - bit 8 sixteen collisions abort
// - bits 6:3 collision count
// - bit 2 excessive deferral, bit 0 deferred
// - store command A always, B on first
// - drop whole pad words, keep partial words
// - length mismatch sets transmitter error
package tbu_pkg;
   //==========================================================
   // register map
   localparam int          ADDR_W        = 12;
   localparam logic [11:0] OFS_TX_DATA   = 12'h000;
   localparam logic [11:0] OFS_TX_STATUS = 12'h004;
   localparam logic [11:0] OFS_TX_CONFIG = 12'h008;
   localparam logic [11:0] OFS_TX_INFO   = 12'h00c;
   localparam int          CFG_SAO_BIT   = 0;
   localparam int          INFO_USED_LO  = 0;
   localparam int          INFO_ERR_BIT  = 8;
   localparam int          INFO_DFC_LO   = 16;
   localparam logic        RST_SAO       = 1'b0;
   //==========================================================
   // command word fields
   localparam int          CA_ALIGN_LO = 24;
   localparam int          CA_OFF_LO   = 16;
   localparam int          CA_FST_BIT  = 13;
   localparam int          CA_LS_BIT   = 12;
   localparam int          CA_SIZE_LO  = 0;
   localparam int          CB_TAG_LO   = 16;
   localparam int          CB_LEN_LO   = 0;
   localparam logic [1:0]  ALIGN_16    = 2'b01;
   localparam logic [1:0]  ALIGN_32    = 2'b10;
   localparam logic [12:0] AMASK_4     = 13'h0003;
   localparam logic [12:0] AMASK_16    = 13'h000f;
   localparam logic [12:0] AMASK_32    = 13'h001f;
   //==========================================================
   // status word fields
   localparam int ST_TAG_LO = 16;
   localparam int ST_SUM    = 15;
   localparam int ST_LOC    = 11;
   localparam int ST_NOC    = 10;
   localparam int ST_LATE   = 9;
   localparam int ST_EXC    = 8;
   localparam int ST_CC_LO  = 3;
   localparam int ST_EXDEF  = 2;
   localparam int ST_RSV1   = 1;
   localparam int ST_DEF    = 0;
   //==========================================================
   // fifo sizes
   localparam int         DF_AW    = 4;
   localparam logic [4:0] DF_DEPTH = 5'h10;
   localparam int         SF_AW    = 2;
   localparam logic [2:0] SF_DEPTH = 3'h4;
   //==========================================================
   // carriers
   typedef struct packed {
      logic [31:0] data;
      logic [3:0]  be;
   } tbu_word_t;
   typedef struct packed {
      logic [15:0] tag;
      logic        loss_carrier;
      logic        no_carrier;
      logic        late_col;
      logic        exc_col;
      logic [3:0]  col_cnt;
      logic        exc_defer;
      logic        deferred;
   } tbu_stat_t;
   typedef enum logic [1:0] {
      U_CMDA = 2'b00,
      U_CMDB = 2'b01,
      U_DATA = 2'b10
   } tbu_ustate_t;
endpackage : tbu_pkg

// ===== hdl/tbu_unpack.sv
// tx buffer unpacker, data fifo, status fifo and apb registers
module tbu_unpack
   import tbu_pkg::*;
(
   input  wire logic              mclk,
   input  wire logic              rst_n,
   input  wire logic [ADDR_W-1:0] paddr,
   input  wire logic              psel,
   input  wire logic              penable,
   input  wire logic              pwrite,
   input  wire logic [31:0]       pwdata,
   output logic [31:0]            prdata,
   output logic                   pready,
   output logic                   pslverr,
   output logic                   out_valid,
   output tbu_word_t              out_word,
   input  wire logic              out_ready,
   input  wire logic              stat_valid,
   input  wire tbu_stat_t         stat_in,
   output logic                   stat_ready,
   output logic                   transmitter_error_flag
);
   //==========================================================
   // state
   typedef struct packed {
      tbu_ustate_t                     ust;
      logic [31:0]                     cmd_a;
      logic [31:0]                     cmd_b0;
      logic [11:0]                     len_sum;
      logic [10:0]                     widx;
      logic [10:0]                     tot_w;
      logic [3:0]                      skip;
      logic [10:0]                     last_w;
      logic                            has_data;
      logic [3:0]                      lo_mask;
      logic [3:0]                      hi_mask;
      logic [15:0][35:0]               df_mem;
      logic [DF_AW-1:0]                df_wp;
      logic [DF_AW-1:0]                df_rp;
      logic [4:0]                      df_cnt;
      logic                            out_vld;
      tbu_word_t                       out_w;
      logic [3:0][31:0]                sf_mem;
      logic [SF_AW-1:0]                sf_wp;
      logic [SF_AW-1:0]                sf_rp;
      logic [2:0]                      sf_cnt;
      logic                            ovr;
      logic                            sao;
      logic                            err_flag;
      logic                            pready;
      logic                            pslverr;
      logic [31:0]                     prdata;
      logic                            stat_rdy;
   } tbu_state_t;

   tbu_state_t s_r;
   tbu_state_t s_nxt;

   //==========================================================
   // address decode
   function automatic logic [2:0] reg_sel(input logic [ADDR_W-1:0] a);
      unique case (a)
         OFS_TX_DATA:   reg_sel = 3'h0;
         OFS_TX_STATUS: reg_sel = 3'h1;
         OFS_TX_CONFIG: reg_sel = 3'h2;
         OFS_TX_INFO:   reg_sel = 3'h3;
         default:       reg_sel = 3'h4;
      endcase
   endfunction : reg_sel

   logic        df_push;
   tbu_word_t   df_in;
   logic        df_pop;
   logic        sf_push;
   logic        sf_pop;
   logic [31:0] sword;
   logic [2:0]  sel;
   logic        keep;
   logic        end_buf;
   logic        set_err;
   logic        clr_err;
   logic [11:0] len_new;
   logic [12:0] span;
   logic [12:0] amask;
   logic [12:0] padded;
   logic [12:0] last_b;
   logic [5:0]  off;
   logic [10:0] size;

   //==========================================================
   // next state
   always_comb begin
      s_nxt   = s_r;
      df_push = 1'b0;
      df_in   = '0;
      df_pop  = 1'b0;
      sf_push = 1'b0;
      sf_pop  = 1'b0;
      keep    = 1'b0;
      end_buf = 1'b0;
      set_err = 1'b0;
      clr_err = 1'b0;
      len_new = 12'h000;
      sel     = reg_sel(paddr);
      off     = pwdata[CA_OFF_LO+5:CA_OFF_LO];
      size    = pwdata[CA_SIZE_LO+10:CA_SIZE_LO];
      span    = {7'h00, off} + {2'h0, size};
      unique case (pwdata[CA_ALIGN_LO+1:CA_ALIGN_LO])
         ALIGN_16: amask = AMASK_16;
         ALIGN_32: amask = AMASK_32;
         default:  amask = AMASK_4;
      endcase
      padded  = (span + amask) & ~amask;
      last_b  = span - 13'h0001;

      // status word: tag, summary and fields, reserved bits zero
      sword                         = '0;
      sword[ST_TAG_LO+15:ST_TAG_LO] = stat_in.tag;
      sword[ST_LOC]                 = stat_in.loss_carrier;
      sword[ST_NOC]                 = stat_in.no_carrier;
      sword[ST_LATE]                = stat_in.late_col;
      sword[ST_EXC]                 = stat_in.exc_col;
      sword[ST_CC_LO+3:ST_CC_LO]    = stat_in.col_cnt;
      sword[ST_EXDEF]               = stat_in.exc_defer;
      sword[ST_DEF]                 = stat_in.deferred;
      sword[ST_SUM] = sword[ST_LOC] | sword[ST_NOC] | sword[ST_LATE] | sword[ST_EXC]
                   | sword[ST_EXDEF] | sword[ST_RSV1];

      //==========================================================
      // apb: first access cycle prepares the answer, effects at the pready edge
      if (psel && penable && !s_r.pready) begin
         s_nxt.prdata  = 32'h0000_0000;
         s_nxt.pslverr = 1'b0;
         s_nxt.pready  = 1'b1;
         unique case (sel)
            3'h0: begin
               // data fifo full stalls the host write
               if (pwrite && s_r.df_cnt == DF_DEPTH) begin
                  s_nxt.pready = 1'b0;
               end
            end
            3'h1: begin
               if (s_r.sf_cnt != 3'h0) begin
                  s_nxt.prdata = s_r.sf_mem[s_r.sf_rp];
               end
            end
            3'h2: s_nxt.prdata[CFG_SAO_BIT] = s_r.sao;
            3'h3: begin
               s_nxt.prdata[INFO_USED_LO+2:INFO_USED_LO] = s_r.ovr ? 3'h0 : s_r.sf_cnt;
               s_nxt.prdata[INFO_ERR_BIT]                = s_r.err_flag;
               s_nxt.prdata[INFO_DFC_LO+4:INFO_DFC_LO]   = s_r.df_cnt;
            end
            default: s_nxt.pslverr = 1'b1;
         endcase
      end
      if (psel && penable && s_r.pready) begin
         s_nxt.pready  = 1'b0;
         s_nxt.pslverr = 1'b0;
         if (pwrite && sel == 3'h2) begin
            s_nxt.sao = pwdata[CFG_SAO_BIT];
         end
         if (pwrite && sel == 3'h3) begin
            clr_err = pwdata[INFO_ERR_BIT];
         end
         if (!pwrite && sel == 3'h1 && s_r.sf_cnt != 3'h0) begin
            sf_pop    = 1'b1;
            s_nxt.ovr = 1'b0;
         end
         //==========================================================
         // buffer unpacker
         if (pwrite && sel == 3'h0) begin
            unique case (s_r.ust)
               U_CMDA: begin
                  s_nxt.cmd_a    = pwdata;
                  df_push        = 1'b1;
                  df_in          = '{data: pwdata, be: 4'hf};
                  s_nxt.tot_w    = padded[12:2];
                  s_nxt.skip     = off[5:2];
                  s_nxt.last_w   = last_b[12:2];
                  s_nxt.has_data = size != 11'h000;
                  s_nxt.lo_mask  = 4'hf << off[1:0];
                  s_nxt.hi_mask  = 4'hf >> (2'h3 - last_b[1:0]);
                  s_nxt.ust      = U_CMDB;
               end
               U_CMDB: begin
                  if (s_r.cmd_a[CA_FST_BIT]) begin
                     df_push      = 1'b1;
                     df_in        = '{data: pwdata, be: 4'hf};
                     s_nxt.cmd_b0 = pwdata;
                     len_new      = {1'b0, s_r.cmd_a[CA_SIZE_LO+10:CA_SIZE_LO]};
                  end else begin
                     if (pwdata != s_r.cmd_b0) begin
                        set_err = 1'b1;
                     end
                     len_new = s_r.len_sum + {1'b0, s_r.cmd_a[CA_SIZE_LO+10:CA_SIZE_LO]};
                  end
                  s_nxt.len_sum = len_new;
                  s_nxt.widx    = 11'h000;
                  if (s_r.tot_w == 11'h000) begin
                     end_buf = 1'b1;
                  end else begin
                     s_nxt.ust = U_DATA;
                  end
               end
               U_DATA: begin
                  // whole offset and filler words fall outside skip..last
                  keep = s_r.has_data && s_r.widx >= {7'h00, s_r.skip}
                       && s_r.widx <= s_r.last_w;
                  if (keep) begin
                     df_push    = 1'b1;
                     df_in.data = pwdata;
                     df_in.be   = (s_r.widx == {7'h00, s_r.skip} ? s_r.lo_mask : 4'hf)
                                & (s_r.widx == s_r.last_w ? s_r.hi_mask : 4'hf);
                  end
                  s_nxt.widx = s_r.widx + 11'h001;
                  if (s_r.widx == s_r.tot_w - 11'h001) begin
                     end_buf = 1'b1;
                  end
               end
               default: s_nxt.ust = U_CMDA;
            endcase
            if (end_buf) begin
               s_nxt.ust = U_CMDA;
               if (s_r.cmd_a[CA_LS_BIT]
                   && s_nxt.len_sum != {1'b0, s_nxt.cmd_b0[CB_LEN_LO+10:CB_LEN_LO]}) begin
                  set_err = 1'b1;
               end
            end
         end
      end

      //==========================================================
      // data fifo and registered output stage
      if (!s_r.out_vld || out_ready) begin
         if (s_r.df_cnt != 5'h00) begin
            df_pop          = 1'b1;
            s_nxt.out_vld   = 1'b1;
            s_nxt.out_w     = s_r.df_mem[s_r.df_rp];
            s_nxt.df_rp     = s_r.df_rp + 4'h1;
         end else begin
            s_nxt.out_vld   = 1'b0;
         end
      end
      if (df_push) begin
         s_nxt.df_mem[s_r.df_wp] = df_in;
         s_nxt.df_wp             = s_r.df_wp + 4'h1;
      end
      if (df_push && !df_pop) begin
         s_nxt.df_cnt = s_r.df_cnt + 5'h01;
      end else if (df_pop && !df_push) begin
         s_nxt.df_cnt = s_r.df_cnt - 5'h01;
      end

      //==========================================================
      // status fifo
      if (stat_valid && s_r.stat_rdy) begin
         if (s_r.sf_cnt == SF_DEPTH || s_r.ovr) begin
            s_nxt.ovr = s_r.sao ? 1'b1 : s_r.ovr;
            if (!s_r.sao) begin
               set_err = 1'b1;
            end
         end else begin
            sf_push = 1'b1;
         end
      end else if (stat_valid && !s_r.sao && s_r.sf_cnt == SF_DEPTH) begin
         set_err = 1'b1;
      end
      if (sf_push) begin
         s_nxt.sf_mem[s_r.sf_wp] = sword;
         s_nxt.sf_wp             = s_r.sf_wp + 2'h1;
      end
      if (sf_pop) begin
         s_nxt.sf_rp = s_r.sf_rp + 2'h1;
      end
      if (sf_push && !sf_pop) begin
         s_nxt.sf_cnt = s_r.sf_cnt + 3'h1;
      end else if (sf_pop && !sf_push) begin
         s_nxt.sf_cnt = s_r.sf_cnt - 3'h1;
      end
      // full fifo without discard holds the engine off
      s_nxt.stat_rdy = s_nxt.sao || (s_nxt.sf_cnt < SF_DEPTH);

      // set wins over a same-cycle clear
      if (set_err) begin
         s_nxt.err_flag = 1'b1;
      end else if (clr_err) begin
         s_nxt.err_flag = 1'b0;
      end
   end

   //==========================================================
   // registers
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         s_r       <= '0;
         s_r.ust   <= U_CMDA;
         s_r.sao   <= RST_SAO;
      end else begin
         s_r <= s_nxt;
      end
   end

   //==========================================================
   // outputs
   assign prdata                 = s_r.prdata;
   assign pready                 = s_r.pready;
   assign pslverr                = s_r.pslverr;
   assign out_valid              = s_r.out_vld;
   assign out_word               = s_r.out_w;
   assign stat_ready             = s_r.stat_rdy;
   assign transmitter_error_flag = s_r.err_flag;
endmodule : tbu_unpack

// ===== tb/tbu_unpack_sva.sv
// port checker of the tx buffer unpacker
module tbu_unpack_sva
   import tbu_pkg::*;
(
   input wire logic              mclk,
   input wire logic              rst_n,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic              psel,
   input wire logic              penable,
   input wire logic              pwrite,
   input wire logic [31:0]       pwdata,
   input wire logic [31:0]       prdata,
   input wire logic              pready,
   input wire logic              pslverr,
   input wire logic              out_valid,
   input wire tbu_word_t         out_word,
   input wire logic              out_ready,
   input wire logic              stat_valid,
   input wire logic              stat_ready,
   input wire logic              transmitter_error_flag
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);
   //==========================================================
   // helpers and assertions
   logic rd_st;
   logic clr;
   assign rd_st = psel && penable && pready && !pwrite && paddr == OFS_TX_STATUS;
   assign clr   = psel && penable && pready && pwrite && paddr == OFS_TX_INFO && pwdata[INFO_ERR_BIT];
   sequence acc_wait_s;
      psel && penable && !pready;
   endsequence
   sequence answer_s;
      ##[1:1000] pready;
   endsequence
   apb_answer_a: assert property (acc_wait_s |-> answer_s)
      else $error("apb access never answered");
   ready_pulse_a: assert property (pready |=> !pready)
      else $error("pready held past one cycle");
   slverr_zero_a: assert property (pslverr |-> pready && prdata == 32'h0)
      else $error("pslverr without pready or with data");
   out_hold_a: assert property (out_valid && !out_ready |=> out_valid && $stable(out_word))
      else $error("data word dropped or changed while stalled");
   lane_valid_a: assert property (out_valid |-> out_word.be != 4'h0)
      else $error("data word with no valid lane");
   full_error_a: assert property (stat_valid && !stat_ready |-> ##[1:2] transmitter_error_flag)
      else $error("refused status did not raise error");
   error_sticky_a: assert property (transmitter_error_flag && !clr |=> transmitter_error_flag)
      else $error("error flag dropped without clear");
   summary_bit_a: assert property (rd_st |-> prdata[ST_SUM] == (|{prdata[11:8], prdata[2:1]}))
      else $error("status summary bit wrong");
   reserved_zero_a: assert property (rd_st |-> prdata[14:12] == 3'h0 && !prdata[7] && !prdata[1])
      else $error("reserved status bits not zero");
endmodule : tbu_unpack_sva

bind tbu_unpack tbu_unpack_sva tbu_unpack_sva_inst (.mclk, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata,
   .prdata, .pready, .pslverr, .out_valid, .out_word, .out_ready, .stat_valid, .stat_ready, .transmitter_error_flag);

// ===== tb/tbu_engine_model.sv
// far-side engine model: drains data words, offers status
module tbu_engine_model
   import tbu_pkg::*;
(
   input  wire logic      mclk,
   input  wire logic      rst_n,
   input  wire logic      stall,
   input  wire logic      out_valid,
   input  wire tbu_word_t out_word,
   output logic           out_ready,
   output logic           stat_valid,
   output tbu_stat_t      stat_in,
   output logic           ok,
   input  wire logic      stat_ready
);
   timeunit 1ns;
   timeprecision 1ps;
   tbu_word_t got[$];
   initial begin
      out_ready = 1'b0;
      stat_valid = 1'b0;
      stat_in = '0;
      ok = 1'b0;
   end
   //==========================================================
   // data drain, stalls on request
   always @(posedge mclk) begin
      if (out_valid && out_ready)
         got.push_back(out_word);
      out_ready <= !stall && rst_n;
   end
   // status offer held until taken or lim edges pass
   task automatic send_stat(input tbu_stat_t s, input int lim);
      int n;
      ok = 1'b0;
      @(posedge mclk);
      stat_valid <= 1'b1;
      stat_in <= s;
      for (n = 0; n < lim && !ok; n++) begin
         @(posedge mclk);
         ok = stat_ready;
      end
      stat_valid <= 1'b0;
      stat_in <= ~s;
   endtask : send_stat
endmodule : tbu_engine_model

// ===== tb/tb_top.sv
// self-checking bench of the tx buffer unpacker
module tb_top
   import tbu_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   `define CHK(g, e) begin compares++; if ((g) !== (e)) begin err_count++; \
      $display("BAD %0t got %h exp %h", $time, g, e); end end
   typedef struct {int off; int size; int al; logic first; logic ls; int len;} tbu_row_t;
   logic              mclk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, stall = 1'b0;
   logic [ADDR_W-1:0] paddr = '0;
   logic [31:0]       pwdata = '0, prdata, rd;
   logic              pready, pslverr, se, out_valid, out_ready, stat_valid, stat_ready, ok;
   logic              transmitter_error_flag;
   tbu_word_t         out_word;
   tbu_stat_t         stat_in;
   int                err_count = 0, compares = 0, expn = 0, i;
   tbu_row_t          rows[8] = '{'{0, 4, 0, 1, 1, 4}, '{7, 79, 1, 1, 1, 79}, '{3, 1, 2, 1, 1, 1},
                                  '{2, 183, 3, 1, 1, 183}, '{29, 5, 2, 1, 1, 5}, '{5, 10, 1, 1, 0, 16},
                                  '{0, 4, 2, 0, 0, 16}, '{1, 2, 0, 0, 1, 16}};
   tbu_stat_t         st[5] = '{'{16'h1111, 1, 0, 0, 0, 0, 0, 0}, '{16'h2222, 0, 1, 0, 0, 3, 0, 1},
                               '{16'h3333, 0, 0, 1, 0, 15, 0, 0}, '{16'h4444, 0, 0, 0, 1, 0, 0, 0},
                               '{16'h5555, 0, 0, 0, 0, 2, 1, 1}};
   always #5 mclk = ~mclk;
   tbu_unpack tbu_unpack_inst (.mclk, .rst_n, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready,
      .pslverr, .out_valid, .out_word, .out_ready, .stat_valid, .stat_in, .stat_ready, .transmitter_error_flag);
   tbu_engine_model tbu_engine_model_inst (.mclk, .rst_n, .stall, .out_valid, .out_word, .out_ready,
      .stat_valid, .stat_in, .ok, .stat_ready);
   //==========================================================
   // tasks
   task automatic tally_and_finish();
      if (err_count == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : tally_and_finish
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (pready !== 1'b1 && n < 3000);
      rd = prdata;
      se = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 3000) begin
         err_count++;
         tally_and_finish();
      end
   endtask : apb
   function automatic logic [31:0] sw(input tbu_stat_t s);
      logic sum;
      sum = s.loss_carrier | s.no_carrier | s.late_col | s.exc_col | s.exc_defer;
      return {s.tag, sum, 3'h0, s.loss_carrier, s.no_carrier, s.late_col, s.exc_col, 1'b0, s.col_cnt,
              s.exc_defer, 1'b0, s.deferred};
   endfunction : sw
   // host side pads to alignment and keeps middle buffers four bytes or more
   task automatic run_buf(input tbu_row_t r, input logic hold);
      int ab, nw, j, k, n, w;
      logic [31:0] ca, cb;
      logic [3:0] be;
      `CHK(tbu_engine_model_inst.got.size(), expn)
      stall <= hold;
      ab = r.al == 1 ? 16 : r.al == 2 ? 32 : 4;
      nw = (r.off + r.size + ab - 1) / ab * ab / 4;
      ca = {6'h0, 2'(r.al), 2'h0, 6'(r.off), 2'h0, r.first, r.ls, 1'b0, 11'(r.size)};
      // tag from packet length: every buffer of one packet repeats the same second word
      cb = {16'(16'h0a00 + r.len), 5'h0, 11'(r.len)};
      apb(1'b1, OFS_TX_DATA, ca);
      apb(1'b1, OFS_TX_DATA, cb);
      for (w = 0; w < nw; w++)
         apb(1'b1, OFS_TX_DATA, 32'hd0d00000 + 32'(w));
      if (hold) begin
         apb(1'b0, OFS_TX_INFO, 32'h0);
         `CHK(rd[20:16], DF_DEPTH)
         stall <= 1'b0;
      end
      k = expn + 1 + (r.first ? 1 : 0);
      expn = k + (r.off + r.size - 1) / 4 - r.off / 4 + 1;
      for (n = 0; n < 3000 && tbu_engine_model_inst.got.size() < expn; n++)
         @(posedge mclk);
      if (n == 3000) begin
         err_count++;
         tally_and_finish();
      end
      `CHK(tbu_engine_model_inst.got[k - 1 - (r.first ? 1 : 0)].data, ca)
      if (r.first) `CHK(tbu_engine_model_inst.got[k - 1].data, cb)
      for (w = r.off / 4; w <= (r.off + r.size - 1) / 4; w++) begin
         for (j = 0; j < 4; j++)
            be[j] = (w * 4 + j >= r.off) && (w * 4 + j < r.off + r.size);
         `CHK(tbu_engine_model_inst.got[k].data, 32'hd0d00000 + 32'(w))
         `CHK(tbu_engine_model_inst.got[k].be, be)
         k++;
      end
   endtask : run_buf
   //==========================================================
   // main sequence
   initial begin
      repeat (4) @(posedge mclk);
      rst_n <= 1'b1;
      apb(1'b0, OFS_TX_CONFIG, 32'h0);
      `CHK(rd[CFG_SAO_BIT], RST_SAO)
      `CHK(stat_ready, 1'b1)
      for (i = 0; i < 8; i++)
         run_buf(rows[i], 1'b0);
      apb(1'b0, OFS_TX_INFO, 32'h0);
      `CHK(rd[INFO_ERR_BIT], 1'b0)
      // 17 words: one parked in the output stage, sixteen fill the fifo
      run_buf(tbu_row_t'{0, 60, 0, 1, 1, 60}, 1'b1);
      run_buf(tbu_row_t'{0, 5, 0, 1, 1, 6}, 1'b0);
      apb(1'b0, OFS_TX_INFO, 32'h0);
      `CHK(rd[INFO_ERR_BIT], 1'b1)
      `CHK(transmitter_error_flag, 1'b1)
      apb(1'b1, OFS_TX_INFO, 32'h100);
      apb(1'b0, 12'h010, 32'h0);
      `CHK({se, rd}, 33'h100000000)
      for (i = 0; i < 4; i++)
         tbu_engine_model_inst.send_stat(st[i], 50);
      apb(1'b0, OFS_TX_INFO, 32'h0);
      `CHK(rd[8:0], 9'h004)
      tbu_engine_model_inst.send_stat(st[4], 5);
      `CHK(ok, 1'b0)
      apb(1'b0, OFS_TX_INFO, 32'h0);
      `CHK(rd[INFO_ERR_BIT], 1'b1)
      for (i = 0; i < 4; i++) begin
         apb(1'b0, OFS_TX_STATUS, 32'h0);
         `CHK(rd, sw(st[i]))
      end
      tbu_engine_model_inst.send_stat(st[4], 50);
      apb(1'b0, OFS_TX_STATUS, 32'h0);
      `CHK(rd, sw(st[4]))
      apb(1'b1, OFS_TX_INFO, 32'h100);
      apb(1'b1, OFS_TX_CONFIG, 32'h1);
      for (i = 0; i < 5; i++)
         tbu_engine_model_inst.send_stat(st[i], 50);
      `CHK(ok, 1'b1)
      apb(1'b0, OFS_TX_INFO, 32'h0);
      `CHK(rd[8:0], 9'h000)
      apb(1'b0, OFS_TX_STATUS, 32'h0);
      `CHK(rd, sw(st[0]))
      apb(1'b0, OFS_TX_INFO, 32'h0);
      `CHK(rd[2:0], 3'h3)
      tally_and_finish();
   end
endmodule : tb_top
